// [rtl/itq_pkg.sv]
// itq_pkg: sizes, register map, codes and timing of the indirect transaction queue
package itq_pkg;
  localparam int NQ      = 8;
  localparam int IDX_W   = 3;
  localparam int CNT_W   = 4;
  localparam int ADDR_W  = 16;
  localparam int HND_W   = 8;
  localparam int AGE_W   = 16;
  localparam int MAXPEND = 7;
  localparam int PCNT_W  = 3;
  localparam int CHAN_W  = 27;
  localparam int BO_W    = 4;
  localparam int RL_W    = 3;
  localparam int FAIL_W  = 8;
  localparam int RCH_W   = 8;

  localparam logic [CNT_W-1:0]  NQ_FULL    = 4'h8;
  localparam logic [ADDR_W-1:0] BCAST_ADDR = 16'hffff;
  localparam logic [BO_W-1:0]   BO_NONE    = 4'hf;

  // register byte addresses
  localparam logic [7:0] REG_CFG     = 8'h00;
  localparam logic [7:0] REG_PERSIST = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_PAN     = 8'h0c;
  localparam logic [7:0] REG_CHAN    = 8'h10;

  // field positions
  localparam int CFG_RL_LSB    = 4;
  localparam int ST_BCS_BIT    = 4;
  localparam int ST_FAIL_LSB   = 8;
  localparam int PAN_SHORT_LSB = 16;

  // reset values
  localparam logic [BO_W-1:0]  BO_RST      = 4'hf;
  localparam logic [RL_W-1:0]  RL_RST      = 3'h3;
  localparam logic [AGE_W-1:0] PERSIST_RST = 16'h01f4;

  // completion status codes
  localparam logic [1:0] ST_SUCCESS  = 2'h0;
  localparam logic [1:0] ST_OVERFLOW = 2'h1;
  localparam logic [1:0] ST_EXPIRED  = 2'h2;

  localparam logic [1:0] SCAN_ORPHAN = 2'h3;

  // age time base: one base superframe
  localparam int CLK_NS       = 10;
  localparam int T_UNIT_NS    = 15360000;
  localparam int UNIT_CYC_DEF = T_UNIT_NS / CLK_NS;

  typedef enum logic [0:0] {ITQ_IDLE, ITQ_BUSY} itq_state_e;
endpackage : itq_pkg

// [rtl/itq_tick.sv]
// itq_tick: divider that turns the core clock into the queue age time base
`timescale 1ns/1ps
module itq_tick #(
  parameter int unsigned DIV = 4
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  output logic      tick_o
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;
  wire           wrap = (cnt == LAST);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt    <= wrap ? '0 : cnt + CW'(1);
      tick_o <= wrap;
    end
  end

  a_tick_spacing: assert property (@(posedge core_clk_i) disable iff (srst_i)
    tick_o |=> !tick_o) else $error("age tick not spaced");
endmodule : itq_tick

// [rtl/itq_top.sv]
// itq_top: coordinator indirect queue plus device poll, retry and orphan duties
// Contract
// - without beacons, poll coordinator on upper request
// - beacon order below 15 enables beacon sync
// - poll request starts pending-data extraction
// - retry limit without ack counts one failure
// - orphan scan request starts orphan scan
// - realignment data loads the attribute base
// - indirect request opens a transaction
// - confirm for requests, comm-status for responses
// - no free storage answers queue-full status
// - same device transactions leave in arrival order
// - frame pending set when more queued (left clear here on broadcast frames)
// - persistence timeout discards and reports lifetime elapsed
// - success needs the requested acknowledgment
// - success discards entry and reports success
// - beacon lists pending addresses and count
// - at most seven addresses, oldest first
// - slot transactions sent in slot, unlisted
// - broadcast pending sets beacon pending, sends after
// - one indirect broadcast per superframe
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module itq_top import itq_pkg::*; #(
  parameter int unsigned UNIT_CYC = UNIT_CYC_DEF
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      req_valid_i,
  input  wire logic [ADDR_W-1:0]         req_addr_i,
  input  wire logic [HND_W-1:0]          req_handle_i,
  input  wire logic                      req_guaranteed_slot_i,
  input  wire logic                      req_ack_i,
  input  wire logic                      req_resp_i,
  output logic                           stat_valid_o,
  output logic      [1:0]                stat_code_o,
  output logic      [HND_W-1:0]          stat_handle_o,
  output logic                           stat_comm_o,
  input  wire logic                      ext_req_i,
  input  wire logic [ADDR_W-1:0]         ext_addr_i,
  input  wire logic                      slot_open_i,
  input  wire logic [ADDR_W-1:0]         slot_addr_i,
  input  wire logic                      bcn_sent_i,
  output logic                           tx_valid_o,
  output logic      [ADDR_W-1:0]         tx_addr_o,
  output logic      [HND_W-1:0]          tx_handle_o,
  output logic                           tx_pend_o,
  output logic                           tx_ackreq_o,
  output logic                           tx_bcast_o,
  input  wire logic                      tx_done_i,
  input  wire logic                      tx_acked_i,
  output logic      [PCNT_W-1:0]         pend_cnt_o,
  output logic      [MAXPEND*ADDR_W-1:0] pend_addr_o,
  output logic                           bcn_fp_o,
  input  wire logic                      poll_req_i,
  output logic                           poll_start_o,
  output logic                           sync_en_o,
  input  wire logic                      try_done_i,
  input  wire logic                      try_acked_i,
  output logic                           comm_fail_o,
  input  wire logic                      scan_req_i,
  input  wire logic [1:0]                scan_type_i,
  input  wire logic [CHAN_W-1:0]         scan_chan_i,
  output logic                           orphan_start_o,
  output logic      [CHAN_W-1:0]         orphan_chan_o,
  input  wire logic                      realign_i,
  input  wire logic [ADDR_W-1:0]         realign_pan_i,
  input  wire logic [ADDR_W-1:0]         realign_short_i,
  input  wire logic [RCH_W-1:0]          realign_chan_i
);
  function automatic logic [IDX_W:0] first_of(input logic [NQ-1:0] v);
    first_of = '0;
    for (int i = NQ - 1; i >= 0; i--) begin
      if (v[i]) first_of = {1'b1, IDX_W'(i)};
    end
  endfunction : first_of

  function automatic logic multi(input logic [NQ-1:0] v);
    multi = |(v & (v - {{(NQ-1){1'b0}}, 1'b1}));
  endfunction : multi

  // attribute registers
  logic [BO_W-1:0]   beacon_order_attr;
  logic [RL_W-1:0]   retry_limit_attr;
  logic [AGE_W-1:0]  persistence_time_attr;
  logic [ADDR_W-1:0] pan_id;
  logic [ADDR_W-1:0] short_addr;
  logic [RCH_W-1:0]  log_chan;
  logic [FAIL_W-1:0] fail_cnt;
  logic [RL_W-1:0]   tries;

  // queue storage, slot 0 is the oldest entry
  logic [NQ-1:0]     e_v;
  logic [NQ-1:0]     e_slot;
  logic [NQ-1:0]     e_ack;
  logic [NQ-1:0]     e_resp;
  logic [ADDR_W-1:0] e_addr [NQ];
  logic [HND_W-1:0]  e_hnd  [NQ];
  logic [AGE_W-1:0]  e_age  [NQ];
  logic [CNT_W-1:0]  count;
  logic [NQ-1:0]     m_ext, m_slot, m_bc, m_exp, m_lst;

  itq_state_e        state;
  itq_state_e        next_state;
  logic [IDX_W-1:0]  sel;
  logic              bcast_sent;
  logic              tick;

  itq_tick #(.DIV(UNIT_CYC)) u_tick (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .tick_o     (tick)
  );

  wire beacon_en = (beacon_order_attr != BO_NONE);
  wire idle      = (state == ITQ_IDLE);

  genvar j;
  generate
    for (j = 0; j < NQ; j++) begin : g_match
      wire bc = (e_addr[j] == BCAST_ADDR);
      assign m_ext[j]  = e_v[j] & ~e_slot[j] & ~bc & (e_addr[j] == ext_addr_i);
      assign m_slot[j] = e_v[j] & e_slot[j] & (e_addr[j] == slot_addr_i);
      assign m_bc[j]   = e_v[j] & bc;
      assign m_lst[j]  = e_v[j] & ~e_slot[j] & ~bc;
      assign m_exp[j] = e_v[j] & (e_age[j] >= persistence_time_attr);
    end
  endgenerate

  wire [IDX_W:0] f_ext  = first_of(m_ext);
  wire [IDX_W:0] f_slot = first_of(m_slot);
  wire [IDX_W:0] f_bc   = first_of(m_bc);
  wire [IDX_W:0] f_exp  = first_of(m_exp);

  // broadcast goes first after the beacon, then slot traffic, then polls;
  // expiry runs only while idle so a removal never moves the entry on air
  wire go_bc   = idle & beacon_en & ~bcast_sent & f_bc[IDX_W];
  wire go_slot = idle & ~go_bc & slot_open_i & f_slot[IDX_W];
  wire go_ext  = idle & ~go_bc & ~go_slot & ext_req_i & f_ext[IDX_W];
  wire go_exp  = idle & ~go_bc & ~go_slot & ~go_ext & f_exp[IDX_W];
  wire start   = go_bc | go_slot | go_ext;
  wire [IDX_W-1:0] start_idx = go_bc ? f_bc[IDX_W-1:0] :
                               go_slot ? f_slot[IDX_W-1:0] : f_ext[IDX_W-1:0];
  wire start_more = go_ext ? multi(m_ext) : (go_slot & multi(m_slot));

  wire done_ok = ~idle & tx_done_i & (~tx_ackreq_o | tx_acked_i);
  wire rem_en  = done_ok | go_exp;
  wire [IDX_W-1:0] rem_idx = done_ok ? sel : f_exp[IDX_W-1:0];
  wire ovf     = req_valid_i & (count == NQ_FULL) & ~rem_en;
  wire ins     = req_valid_i & ~ovf;
  wire [CNT_W-1:0] ins_idx    = count - CNT_W'(rem_en);
  wire [CNT_W-1:0] next_count = count + CNT_W'(ins) - CNT_W'(rem_en);

  generate
    for (j = 0; j < NQ; j++) begin : g_slot
      localparam int S = (j < NQ - 1) ? j + 1 : j;
      localparam logic HAS_UP = (j < NQ - 1);
      wire sh = rem_en & (IDX_W'(j) >= rem_idx);
      wire ld = ins & (ins_idx == CNT_W'(j));
      wire [AGE_W-1:0] s_age = sh ? e_age[S] : e_age[j];
      wire [AGE_W-1:0] next_age = (tick && s_age != '1) ? s_age + AGE_W'(1) : s_age;
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          e_v[j] <= 1'b0;
        end else begin
          e_v[j] <= ld | (sh ? (HAS_UP & e_v[S]) : e_v[j]);
        end
      end
      always_ff @(posedge core_clk_i) begin
        if (ld) begin
          e_addr[j] <= req_addr_i;
          e_hnd[j]  <= req_handle_i;
          {e_slot[j], e_ack[j], e_resp[j]} <= {req_guaranteed_slot_i, req_ack_i, req_resp_i};
        end else if (sh) begin
          e_addr[j] <= e_addr[S];
          e_hnd[j]  <= e_hnd[S];
          {e_slot[j], e_ack[j], e_resp[j]} <= {e_slot[S], e_ack[S], e_resp[S]};
        end
        e_age[j] <= ld ? '0 : next_age;
      end
    end
  endgenerate

  // beacon pending list, oldest first, capped
  logic [MAXPEND*ADDR_W-1:0] lst;
  logic [PCNT_W-1:0]         lst_cnt;
  always_comb begin
    lst     = '0;
    lst_cnt = '0;
    for (int i = 0; i < NQ; i++) begin
      if (m_lst[i] && lst_cnt < PCNT_W'(MAXPEND)) begin
        lst[lst_cnt*ADDR_W +: ADDR_W] = e_addr[i];
        lst_cnt = lst_cnt + PCNT_W'(1);
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ITQ_IDLE: if (start) next_state = ITQ_BUSY;
      ITQ_BUSY: if (tx_done_i) next_state = ITQ_IDLE;
      default:  next_state = ITQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state      <= ITQ_IDLE;
      count      <= '0;
      tx_valid_o <= 1'b0;
      bcast_sent <= 1'b1;
    end else begin
      state      <= next_state;
      count      <= next_count;
      tx_valid_o <= start | (tx_valid_o & ~tx_done_i);
      bcast_sent <= go_bc | (bcast_sent & ~bcn_sent_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sel         <= '0;
      tx_addr_o   <= '0;
      tx_handle_o <= '0;
      tx_pend_o   <= 1'b0;
      tx_ackreq_o <= 1'b0;
      tx_bcast_o  <= 1'b0;
    end else if (start) begin
      sel         <= start_idx;
      tx_addr_o   <= e_addr[start_idx];
      tx_handle_o <= e_hnd[start_idx];
      tx_pend_o   <= start_more;
      tx_ackreq_o <= e_ack[start_idx] & ~go_bc;
      tx_bcast_o  <= go_bc;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      stat_valid_o  <= 1'b0;
      stat_code_o   <= ST_SUCCESS;
      stat_handle_o <= '0;
      stat_comm_o   <= 1'b0;
      pend_cnt_o    <= '0;
      pend_addr_o   <= '0;
      bcn_fp_o      <= 1'b0;
    end else begin
      stat_valid_o  <= ovf | rem_en;
      stat_code_o   <= ovf ? ST_OVERFLOW : (done_ok ? ST_SUCCESS : ST_EXPIRED);
      stat_handle_o <= ovf ? req_handle_i : e_hnd[rem_idx];
      stat_comm_o   <= ovf ? req_resp_i : e_resp[rem_idx];
      pend_cnt_o    <= lst_cnt;
      pend_addr_o   <= lst;
      bcn_fp_o      <= beacon_en & f_bc[IDX_W];
    end
  end

  // device duties: polling, sync mode, retry failures, orphan scan
  wire try_fail = try_done_i & ~try_acked_i & (tries + RL_W'(1) >= retry_limit_attr);
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      poll_start_o   <= 1'b0;
      sync_en_o      <= 1'b0;
      comm_fail_o    <= 1'b0;
      tries          <= '0;
      fail_cnt       <= '0;
      orphan_start_o <= 1'b0;
      orphan_chan_o  <= '0;
    end else begin
      poll_start_o   <= poll_req_i;
      sync_en_o      <= beacon_en;
      comm_fail_o    <= try_fail;
      tries          <= (try_done_i & (try_acked_i | try_fail)) ? '0 :
                        tries + RL_W'(try_done_i);
      fail_cnt       <= fail_cnt + FAIL_W'(try_fail);
      orphan_start_o <= scan_req_i & (scan_type_i == SCAN_ORPHAN);
      if (scan_req_i && scan_type_i == SCAN_ORPHAN) orphan_chan_o <= scan_chan_i;
    end
  end

  // wishbone slave, answers every access one cycle after the strobe
  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_hit & wb_we_i;
  wire [31:0] rd_cfg  = 32'(beacon_order_attr) | (32'(retry_limit_attr) << CFG_RL_LSB);
  wire [31:0] rd_st   = 32'(count) | (32'(bcast_sent) << ST_BCS_BIT) |
                        (32'(fail_cnt) << ST_FAIL_LSB);
  wire [31:0] rd_pan  = 32'(pan_id) | (32'(short_addr) << PAN_SHORT_LSB);
  wire [31:0] rd_data = (wb_adr_i == REG_CFG)     ? rd_cfg :
                        (wb_adr_i == REG_PERSIST) ? 32'(persistence_time_attr) :
                        (wb_adr_i == REG_STATUS)  ? rd_st :
                        (wb_adr_i == REG_PAN)     ? rd_pan :
                        (wb_adr_i == REG_CHAN)    ? 32'(log_chan) : 32'h0000_0000;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_data : '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      beacon_order_attr     <= BO_RST;
      retry_limit_attr      <= RL_RST;
      persistence_time_attr <= PERSIST_RST;
    end else if (wb_wr) begin
      if (wb_adr_i == REG_CFG && wb_sel_i[0]) begin
        beacon_order_attr <= wb_dat_i[BO_W-1:0];
        retry_limit_attr  <= wb_dat_i[CFG_RL_LSB +: RL_W];
      end
      if (wb_adr_i == REG_PERSIST && wb_sel_i[0]) persistence_time_attr[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == REG_PERSIST && wb_sel_i[1]) persistence_time_attr[15:8] <= wb_dat_i[15:8];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pan_id     <= '1;
      short_addr <= '1;
      log_chan   <= '0;
    end else if (realign_i) begin
      pan_id     <= realign_pan_i;
      short_addr <= realign_short_i;
      log_chan   <= realign_chan_i;
    end
  end

  // checks
  logic [1:0] bc_starts;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || bcn_sent_i) bc_starts <= '0;
    else if (go_bc && bc_starts != 2'h3) bc_starts <= bc_starts + 2'h1;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  a_queue_full: assert property (ovf |=> stat_valid_o && stat_code_o == ST_OVERFLOW)
    else $error("overflow not reported");
  a_entry_expiry: assert property (go_exp |=> stat_valid_o && stat_code_o == ST_EXPIRED)
    else $error("expiry not reported");
  a_done_success: assert property (tx_valid_o && tx_done_i && (!tx_ackreq_o || tx_acked_i)
    |=> stat_valid_o && stat_code_o == ST_SUCCESS && count <= $past(count))
    else $error("success not reported");
  a_ack_needed: assert property (tx_valid_o && tx_done_i && tx_ackreq_o && !tx_acked_i
    |=> !(stat_valid_o && stat_code_o == ST_SUCCESS))
    else $error("success without ack");
  a_pend_limit: assert property (pend_cnt_o <= PCNT_W'(MAXPEND))
    else $error("pending list too long");
  a_bcast_once: assert property (bc_starts <= 2'h1)
    else $error("second broadcast in superframe");
  a_slot_send: assert property (go_slot |=> tx_valid_o && tx_addr_o == $past(slot_addr_i)
    && !tx_bcast_o)
    else $error("slot transaction not sent");
  a_retry_fail: assert property (try_fail |=> comm_fail_o
    && fail_cnt == $past(fail_cnt) + FAIL_W'(1))
    else $error("failure not counted");
  a_orphan_scan: assert property (scan_req_i && scan_type_i == SCAN_ORPHAN
    |=> orphan_start_o && orphan_chan_o == $past(scan_chan_i))
    else $error("orphan scan not started");

  c_overflow: cover property (ovf);
  c_expiry:   cover property (go_exp);
  c_bcast:    cover property (go_bc ##[1:20] tx_done_i);
endmodule : itq_top

// [tb/itq_remote.sv]
// itq_remote: remote device answering the coordinator's indirect frames
`timescale 1ns/1ps
module itq_remote (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       tx_valid_i,
  input  wire logic       ack_en_i,
  input  wire logic [3:0] delay_i,
  output logic            tx_done_o,
  output logic            tx_acked_o
);
  logic [3:0] cnt;
  wire        fire = tx_valid_i && !tx_done_o && cnt == delay_i;

  always_ff @(posedge core_clk_i) begin
    if (srst_i || !tx_valid_i || tx_done_o) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
  end

  always_ff @(posedge core_clk_i) begin
    tx_done_o <= !srst_i && fire;
    // outside the done pulse the ack line means nothing, so it keeps moving
    tx_acked_o <= srst_i ? 1'b0 : (fire ? ack_en_i : ~tx_acked_o);
  end
endmodule : itq_remote

// [tb/itq_top_test.sv]
// itq_top_test: self-checking bench for the indirect transaction queue
`timescale 1ns/1ps
module itq_top_test import itq_pkg::*;;
  logic clk, srst, cyc, stb, we, ack, rqv, rslot, rack, rresp, svalid, scomm, ext, gslot;
  logic bsent, txv, txp, txar, txb, txd, txa, bfp, poll, pst, syn, tdone, tack, cfail;
  logic scan, ost, rlg, ack_en;
  logic [7:0]  adr, shnd, txh, rhnd, rch;
  logic [3:0]  sel, dly;
  logic [31:0] wdat, rdat, q;
  logic [15:0] raddr, eaddr, gaddr, txa_o, rpan, rshort;
  logic [1:0]  scode, stype, s_code;
  logic [2:0]  pcnt;
  logic [111:0] paddr;
  logic [26:0] schan, ochan;
  logic [7:0]  s_hnd;
  logic        s_comm;
  int n_fail = 0, checked = 0, n_stat = 0;

  itq_top #(.UNIT_CYC(4)) uut (
    .core_clk_i(clk), .srst_i(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .req_valid_i(rqv), .req_addr_i(raddr), .req_handle_i(rhnd), .req_guaranteed_slot_i(rslot),
    .req_ack_i(rack), .req_resp_i(rresp), .stat_valid_o(svalid), .stat_code_o(scode),
    .stat_handle_o(shnd), .stat_comm_o(scomm), .ext_req_i(ext), .ext_addr_i(eaddr),
    .slot_open_i(gslot), .slot_addr_i(gaddr), .bcn_sent_i(bsent), .tx_valid_o(txv),
    .tx_addr_o(txa_o), .tx_handle_o(txh), .tx_pend_o(txp), .tx_ackreq_o(txar),
    .tx_bcast_o(txb), .tx_done_i(txd), .tx_acked_i(txa), .pend_cnt_o(pcnt),
    .pend_addr_o(paddr), .bcn_fp_o(bfp), .poll_req_i(poll), .poll_start_o(pst),
    .sync_en_o(syn), .try_done_i(tdone), .try_acked_i(tack), .comm_fail_o(cfail),
    .scan_req_i(scan), .scan_type_i(stype), .scan_chan_i(schan), .orphan_start_o(ost),
    .orphan_chan_o(ochan), .realign_i(rlg), .realign_pan_i(rpan),
    .realign_short_i(rshort), .realign_chan_i(rch));

  itq_remote remote (.core_clk_i(clk), .srst_i(srst), .tx_valid_i(txv), .ack_en_i(ack_en),
    .delay_i(dly), .tx_done_o(txd), .tx_acked_o(txa));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (svalid === 1'b1) begin
    n_stat++;
    s_code = scode;
    s_hnd = shnd;
    s_comm = scomm;
  end

  task automatic finish_test;
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk(ack === 1'b1, "bus without ack");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic enq(input logic [15:0] a, input logic [7:0] h, input logic g, k, r);
    @(posedge clk);
    rqv <= 1'b1;
    raddr <= a;
    rhnd <= h;
    rslot <= g;
    rack <= k;
    rresp <= r;
    @(posedge clk);
    rqv <= 1'b0;
  endtask : enq

  task automatic pulse_ext(input logic [15:0] a, input logic g);
    @(posedge clk);
    ext <= !g;
    gslot <= g;
    eaddr <= a;
    gaddr <= a;
    @(posedge clk);
    ext <= 1'b0;
    gslot <= 1'b0;
  endtask : pulse_ext

  task automatic exp_tx(input logic [15:0] a, input logic [7:0] h, input logic p, r, ok, c);
    int n, s;
    s = n_stat;
    n = 0;
    while (txv !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(txa_o === a && txh === h && txar === r && txb === (a == BCAST_ADDR), "frame fields");
    chk(p === 1'bx || txp === p, "frame pending");
    n = 0;
    while (n_stat == s && n < 30) begin
      @(posedge clk);
      n++;
    end
    chk(ok ? (n_stat == s + 1 && s_code === ST_SUCCESS && s_hnd === h && s_comm === c)
           : n_stat == s, "completion status");
  endtask : exp_tx

  task automatic t_poll;
    @(posedge clk);
    poll <= 1'b1;
    @(posedge clk);
    poll <= 1'b0;
    @(posedge clk);
    chk(pst === 1'b1 && syn === 1'b0, "poll start");
    @(posedge clk);
    chk(pst === 1'b0, "poll pulse long");
  endtask : t_poll

  task automatic t_regs;
    wb(1'b0, REG_CFG, 32'h0);
    chk(q === 32'h0000003f, "cfg reset");
    wb(1'b0, REG_PERSIST, 32'h0);
    chk(q === 32'h000001f4, "persist reset");
    sel <= 4'h2;
    wb(1'b1, REG_PERSIST, 32'h0000ff77);
    sel <= 4'hf;
    wb(1'b0, REG_PERSIST, 32'h0);
    chk(q === 32'h0000fff4, "lane select");
    wb(1'b1, REG_CFG, 32'h00000032);
    repeat (2) @(posedge clk);
    chk(syn === 1'b1, "sync enable");
    wb(1'b0, 8'h20, 32'h0);
    chk(q === 32'h0, "unmapped read");
  endtask : t_regs

  task automatic t_retry;
    // an acked try in the middle must restart the retry count
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      tdone <= 1'b1;
      tack <= (i == 1);
      @(posedge clk);
      tdone <= 1'b0;
      tack <= 1'b0;
      @(posedge clk);
      chk(cfail === (i == 4), "comm failure");
    end
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[15:8] === 8'h01 && q[3:0] === 4'h0, "fail count");
  endtask : t_retry

  task automatic t_orphan;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      scan <= 1'b1;
      stype <= (i == 1) ? SCAN_ORPHAN : 2'h0;
      @(posedge clk);
      scan <= 1'b0;
      @(posedge clk);
      chk(ost === (i == 1) && (i == 0 || ochan === 27'h0000801), "orphan scan");
    end
    @(posedge clk);
    rlg <= 1'b1;
    @(posedge clk);
    rlg <= 1'b0;
    wb(1'b0, REG_PAN, 32'h0);
    chk(q === 32'h00421234, "realigned pan");
    wb(1'b0, REG_CHAN, 32'h0);
    chk(q === 32'h0000000b, "realigned channel");
  endtask : t_orphan

  task automatic t_queue;
    enq(16'h0a01, 8'h11, 1'b0, 1'b1, 1'b0);
    enq(16'h0b02, 8'h13, 1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk(pcnt === 3'h1 && paddr[15:0] === 16'h0a01, "beacon list");
    enq(16'h0a01, 8'h12, 1'b0, 1'b0, 1'b1);
    ack_en <= 1'b0;
    dly <= 4'h3;
    pulse_ext(16'h0a01, 1'b0);
    exp_tx(16'h0a01, 8'h11, 1'b1, 1'b1, 1'b0, 1'b0);
    ack_en <= 1'b1;
    dly <= 4'h0;
    pulse_ext(16'h0a01, 1'b0);
    exp_tx(16'h0a01, 8'h11, 1'b1, 1'b1, 1'b1, 1'b0);
    pulse_ext(16'h0a01, 1'b0);
    exp_tx(16'h0a01, 8'h12, 1'b0, 1'b0, 1'b1, 1'b1);
    pulse_ext(16'h0b02, 1'b1);
    exp_tx(16'h0b02, 8'h13, 1'b0, 1'b0, 1'b1, 1'b0);
  endtask : t_queue

  task automatic t_full;
    int s, n;
    for (int i = 0; i < 8; i++) enq(16'h0100 + 16'(i), 8'(i), 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk(pcnt === 3'h7 && paddr[15:0] === 16'h0100 && paddr[111:96] === 16'h0106,
        "oldest seven");
    s = n_stat;
    enq(16'h0200, 8'h99, 1'b0, 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    chk(n_stat == s + 1 && s_code === ST_OVERFLOW && s_hnd === 8'h99, "overflow");
    wb(1'b1, REG_PERSIST, 32'h00000002);
    n = 0;
    while (n_stat < s + 9 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(n_stat == s + 9 && s_code === ST_EXPIRED, "lifetime elapsed");
  endtask : t_full

  task automatic t_bcast;
    logic seen;
    wb(1'b1, REG_PERSIST, 32'h000001f4);
    enq(BCAST_ADDR, 8'h21, 1'b0, 1'b1, 1'b0);
    enq(BCAST_ADDR, 8'h22, 1'b0, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    chk(bfp === 1'b1 && pcnt === 3'h0, "beacon pending bit");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      bsent <= 1'b1;
      @(posedge clk);
      bsent <= 1'b0;
      exp_tx(BCAST_ADDR, 8'h21 + 8'(i), 1'bx, 1'b0, 1'b1, 1'b0);
      seen = 1'b0;
      // a receiver left on this long after the beacon would catch a second one
      repeat (20) begin
        @(posedge clk);
        seen = seen | (txv === 1'b1);
      end
      chk(!seen && bfp === (i == 0), "one broadcast per superframe");
    end
  endtask : t_bcast

  initial begin
    {cyc, stb, we, rqv, rslot, rack, rresp, ext, gslot, bsent, poll, tdone, tack} = '0;
    {scan, rlg} = '0;
    ack_en = 1'b1;
    {adr, rhnd, rch, sel, dly, wdat, raddr, eaddr, gaddr, stype} = '0;
    sel = 4'hf;
    schan = 27'h0000801;
    rpan = 16'h1234;
    rshort = 16'h0042;
    rch = 8'h0b;
    srst = 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_poll();
    t_regs();
    t_retry();
    t_orphan();
    t_queue();
    t_full();
    t_bcast();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule : itq_top_test
